// *** bench/tb.sv ***
/*
 * Self-checking bench for the wake and offload control block.
 * Assumes the package constants and the receive MAC model on the frame side.
 */
`timescale 1ns/100ps
module tb;
   import wocns_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, resume_done, rx_frame_end, rx_dst_byte_valid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, ns_dst_hit;
   logic rx_is_arp, rx_is_ns, rx_is_ipv6, rx_is_v6_syn, rx_is_v4_syn, rx_eth_dst_ok, rx_targets_me;
   logic rx_fcs_ok, rx_ip_csum_ok, rx_l4_csum_ok, verdict_valid, frame_pass, arp_respond, ns_respond, wake_req;
   logic [7:0] rx_dst_byte;
   logic [127:0] rx_ns_target, advert_src_addr;
   int errors = 0;
   int n_checks = 0;
   localparam logic [127:0] A = 128'h2001_0db8_0000_0000_0000_0000_00aa_bb01;
   localparam logic [127:0] B = 128'hfe80_0000_0000_0000_0211_22ff_fe33_4455;
   localparam logic [127:0] T = 128'hfe80_0000_0000_0000_0000_0000_0000_0777;
   localparam logic [8:0] F_ARP = 9'h11f;
   localparam logic [8:0] F_NS = 9'h09f;
   localparam logic [8:0] F_V6 = 9'h057;
   localparam logic [8:0] F_V4 = 9'h037;

   wocns_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_dst_byte_valid, .rx_dst_byte,
      .rx_frame_end, .rx_is_arp, .rx_is_ns, .rx_is_ipv6, .rx_is_v6_syn, .rx_is_v4_syn, .rx_eth_dst_ok,
      .rx_targets_me, .rx_fcs_ok, .rx_ip_csum_ok, .rx_l4_csum_ok, .rx_ns_target, .resume_done, .verdict_valid,
      .frame_pass, .arp_respond, .ns_respond, .ns_dst_hit, .advert_src_addr, .wake_req);
   wocns_rx_mac mac (.aclk, .rx_dst_byte_valid, .rx_dst_byte, .rx_frame_end, .rx_is_arp, .rx_is_ns, .rx_is_ipv6,
      .rx_is_v6_syn, .rx_is_v4_syn, .rx_eth_dst_ok, .rx_targets_me, .rx_fcs_ok, .rx_ip_csum_ok, .rx_l4_csum_ok,
      .rx_ns_target, .resume_done);

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string what, input logic [127:0] seen, input logic [127:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   // Both channels are offered together and each is released at the edge that takes it.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      chk("bvalid", s_axi_bvalid, 1'b1);
      chk("bresp", s_axi_bresp, er);
   endtask : wr

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      chk("rvalid", s_axi_rvalid, 1'b1);
      chk("rdata", s_axi_rdata, exp);
      chk("rresp", s_axi_rresp, er);
   endtask : rchk

   // e holds pass, arp reply, ns reply, entry hits and wake.
   task automatic frm(input logic [127:0] dst, input logic [8:0] f, input logic [5:0] e);
      mac.send(dst, f, T);
      #1;
      chk("verdict", {verdict_valid, frame_pass, arp_respond, ns_respond, ns_dst_hit, wake_req}, {1'b1, e});
   endtask : frm

   task automatic t_regs();
      rchk(OFF_CTRL_STATUS, CTRL_RESET, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         rchk(OFF_MATCH0_BASE + 12'(4 * i), ENTRY_RESET, RESP_OKAY);
         rchk(OFF_MATCH1_BASE + 12'(4 * i), ENTRY_RESET, RESP_OKAY);
      end
      wr(OFF_CTRL_STATUS, 32'hffff_ffff, RESP_OKAY);
      rchk(OFF_CTRL_STATUS, CTRL_RW_MASK, RESP_OKAY);
      wr(OFF_CTRL_STATUS, 32'h0000_0000, RESP_OKAY);
      rchk(12'h700, 32'h0000_0000, RESP_SLVERR);
      wr(12'h700, 32'h0000_0001, RESP_SLVERR);
   endtask : t_regs

   task automatic t_arp();
      wr(OFF_CTRL_STATUS, 32'h0000_0004, RESP_OKAY);
      frm(T, F_ARP, 6'b010000);
      rchk(OFF_CTRL_STATUS, 32'h0000_0044, RESP_OKAY);
      wr(OFF_CTRL_STATUS, 32'h0000_0044, RESP_OKAY);
      rchk(OFF_CTRL_STATUS, 32'h0000_0004, RESP_OKAY);
      wr(OFF_CTRL_STATUS, 32'h0000_0404, RESP_OKAY);
      frm(T, F_ARP, 6'b110000);
      frm(T, F_ARP ^ 9'h002, 6'b100000);
      frm(T, F_ARP ^ 9'h001, 6'b100000);
      wr(OFF_CTRL_STATUS, 32'h8000_0404, RESP_OKAY);
      frm(T, F_ARP ^ 9'h003, 6'b110000);
      frm(T, F_ARP ^ 9'h004, 6'b100000);
      wr(OFF_CTRL_STATUS, 32'h0000_0040, RESP_OKAY);
      frm(T, F_ARP, 6'b100000);
   endtask : t_arp

   task automatic t_syn();
      wr(OFF_CTRL_STATUS, 32'h0000_0043, RESP_OKAY);
      frm(T, F_V6, 6'b100001);
      frm(T, F_V4, 6'b100001);
      rchk(OFF_CTRL_STATUS, 32'h0000_0033, RESP_OKAY);
      wr(OFF_RESUME_OPTS, 32'h0000_0003, RESP_OKAY);
      mac.resume();
      rchk(OFF_CTRL_STATUS, 32'h0000_0000, RESP_OKAY);
      frm(T, F_V6, 6'b100000);
      frm(T, F_V4, 6'b100000);
      rchk(OFF_CTRL_STATUS, 32'h0000_0030, RESP_OKAY);
      wr(OFF_CTRL_STATUS, 32'h0000_0030, RESP_OKAY);
      rchk(OFF_CTRL_STATUS, 32'h0000_0000, RESP_OKAY);
   endtask : t_syn

   task automatic t_ns();
      for (int i = 0; i < 4; i++) begin
         wr(OFF_MATCH0_BASE + 12'(4 * i), A[32 * i +: 32], RESP_OKAY);
         wr(OFF_MATCH1_BASE + 12'(4 * i), B[32 * i +: 32], RESP_OKAY);
         rchk(OFF_MATCH0_BASE + 12'(4 * i), A[32 * i +: 32], RESP_OKAY);
         rchk(OFF_MATCH1_BASE + 12'(4 * i), B[32 * i +: 32], RESP_OKAY);
      end
      wr(OFF_CTRL_STATUS, 32'h0000_0308, RESP_OKAY);
      frm(A, F_NS, 6'b101010);
      chk("advert", advert_src_addr, A);
      wr(OFF_CTRL_STATUS, 32'h0000_0008, RESP_OKAY);
      frm(B, F_NS, 6'b001100);
      chk("advert", advert_src_addr, T);
      frm({SOLICIT_PREFIX, B[127:104]}, F_NS, 6'b001100);
      frm(A, F_NS ^ 9'h010, 6'b100000);
      rchk(OFF_CTRL_STATUS, 32'h0000_0088, RESP_OKAY);
      wr(OFF_CTRL_STATUS, 32'h0000_0080, RESP_OKAY);
      rchk(OFF_CTRL_STATUS, 32'h0000_0000, RESP_OKAY);
      frm(A, F_NS, 6'b100000);
   endtask : t_ns

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs();
      t_arp();
      t_syn();
      t_ns();
      complete_run();
   end

   // The tests need about 470 cycles; 40000 cycles, some 85 times that, means a hang.
   initial begin
      #400000;
      errors++;
      complete_run();
   end
endmodule : tb

// *** bench/wocns_rx_mac.sv ***
/*
 * Receive MAC model for the wake and offload control block: shifts the IPv6 destination in,
 * then presents a one-cycle frame summary, and pulses the resume completion.
 * Assumes the bench calls its tasks from one process and that aclk is the block's clock.
 */
`timescale 1ns/100ps
module wocns_rx_mac (
   input wire logic aclk,
   output logic rx_dst_byte_valid,
   output logic [7:0] rx_dst_byte,
   output logic rx_frame_end,
   output logic rx_is_arp,
   output logic rx_is_ns,
   output logic rx_is_ipv6,
   output logic rx_is_v6_syn,
   output logic rx_is_v4_syn,
   output logic rx_eth_dst_ok,
   output logic rx_targets_me,
   output logic rx_fcs_ok,
   output logic rx_ip_csum_ok,
   output logic rx_l4_csum_ok,
   output logic [127:0] rx_ns_target,
   output logic resume_done
);
   initial begin
      {rx_dst_byte_valid, rx_frame_end, resume_done, rx_is_ipv6} = 4'h0;
      rx_dst_byte = 8'h00;
      {rx_is_arp, rx_is_ns, rx_is_v6_syn, rx_is_v4_syn, rx_eth_dst_ok} = 5'h00;
      {rx_targets_me, rx_fcs_ok, rx_ip_csum_ok, rx_l4_csum_ok} = 4'h0;
      rx_ns_target = 128'h0;
   end

   // Flag order in f: arp, ns, v6 syn, v4 syn, eth dst ok, targets me, fcs, ip csum, l4 csum.
   task automatic send(input logic [127:0] dst, input logic [8:0] f, input logic [127:0] tgt);
      for (int i = 0; i < 16; i++) begin
         @(posedge aclk);
         rx_dst_byte_valid <= 1'b1;
         rx_dst_byte <= dst[127 - 8 * i -: 8];
      end
      @(posedge aclk);
      rx_dst_byte_valid <= 1'b0;
      rx_dst_byte <= ~rx_dst_byte;
      rx_frame_end <= 1'b1;
      {rx_is_arp, rx_is_ns, rx_is_v6_syn, rx_is_v4_syn, rx_eth_dst_ok, rx_targets_me, rx_fcs_ok, rx_ip_csum_ok,
       rx_l4_csum_ok} <= f;
      rx_is_ipv6 <= f[7] | f[6];
      rx_ns_target <= tgt;
      @(posedge aclk);
      rx_frame_end <= 1'b0;
      // The summary is only valid with the frame end, so it is scrambled afterwards to expose late sampling.
      {rx_is_arp, rx_is_ns, rx_is_v6_syn, rx_is_v4_syn, rx_eth_dst_ok, rx_targets_me, rx_fcs_ok, rx_ip_csum_ok,
       rx_l4_csum_ok} <= ~f;
      rx_is_ipv6 <= ~(f[7] | f[6]);
      rx_ns_target <= ~tgt;
   endtask : send

   task automatic resume();
      @(posedge aclk);
      resume_done <= 1'b1;
      @(posedge aclk);
      resume_done <= 1'b0;
   endtask : resume
endmodule : wocns_rx_mac

// *** inc/wocns_pkg.sv ***
/*
 * Constants for the wake and offload control block: register offsets, field positions,
 * reset values, bus answer codes and the solicited-node prefix.
 * Assumes a 12-bit AXI4-Lite byte address and 32-bit data.
 */
package wocns_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFF_CTRL_STATUS = 12'h600;
   localparam logic [11:0] OFF_RESUME_OPTS = 12'h604;
   localparam logic [11:0] OFF_MATCH0_BASE = 12'h610;
   localparam logic [11:0] OFF_MATCH1_BASE = 12'h650;
   localparam int BIT_CSUM_OFF = 31;
   localparam int BIT_FWD_ARP = 10;
   localparam int BIT_FWD_NS = 9;
   localparam int BIT_ADV_SEL = 8;
   localparam int BIT_NS_FLAG = 7;
   localparam int BIT_ARP_FLAG = 6;
   localparam int BIT_V6_RCD = 5;
   localparam int BIT_V4_RCD = 4;
   localparam int BIT_NS_ON = 3;
   localparam int BIT_ARP_ON = 2;
   localparam int BIT_V6_WAKE = 1;
   localparam int BIT_V4_WAKE = 0;
   localparam int BIT_RES_CLR_FLAGS = 0;
   localparam int BIT_RES_CLR_ENABLES = 1;
   localparam logic [31:0] CTRL_RW_MASK = 32'h8000_070f;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] ENTRY_RESET = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [103:0] SOLICIT_PREFIX = 104'hff02_0000_0000_0000_0000_0001_ff;
endpackage : wocns_pkg

// *** rtl/wocns_ctrl.sv ***
/*
 * Wake and offload control block: control/status register, resume options register,
 * two IPv6 destination match entries, frame qualification and verdicts.
 * Assumes the receive MAC presents one-cycle frame summaries synchronous to aclk and
 * shifts the IPv6 destination in, first received byte first, before the summary.
 */
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps

// Contract
// - Checksum on: need IP, TCP and FCS good.
// - Checksum off: check FCS only.
// - Forward ARP bit: discard or pass handled ARP.
// - Forward NS bit: discard or pass handled NS.
// - Advert source: entry or solicitation target.
// - Valid NS sets solicit received flag.
// - Valid ARP sets flag, write-one clears.
// - Valid IPv6 SYN sets flag, write-one clears.
// - Valid IPv4 SYN sets its flag.
// - Resume option clears both SYN flags.
// - Answer NS only while enabled.
// - Answer ARP only while enabled.
// - IPv6 SYN wakes only while enabled.
// - IPv4 SYN wakes only while enabled.
// - Resume option clears both SYN wake enables.
// - Two 128-bit entries, four words, low first.
// - Match only own, multicast or broadcast frames.
// - Compare IPv6 destination with both entries.
// - Solicited-node: compare entry top 24 bits.
// - First address byte lands at bits 127:120.
module wocns_ctrl
   import wocns_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rx_dst_byte_valid,
   input wire logic [7:0] rx_dst_byte,
   input wire logic rx_frame_end,
   input wire logic rx_is_arp,
   input wire logic rx_is_ns,
   input wire logic rx_is_ipv6,
   input wire logic rx_is_v6_syn,
   input wire logic rx_is_v4_syn,
   input wire logic rx_eth_dst_ok,
   input wire logic rx_targets_me,
   input wire logic rx_fcs_ok,
   input wire logic rx_ip_csum_ok,
   input wire logic rx_l4_csum_ok,
   input wire logic [127:0] rx_ns_target,
   input wire logic resume_done,
   output logic verdict_valid,
   output logic frame_pass,
   output logic arp_respond,
   output logic ns_respond,
   output logic [1:0] ns_dst_hit,
   output logic [127:0] advert_src_addr,
   output logic wake_req
);

   logic [31:0] ctrl;
   logic [3:0] flags;
   logic [1:0] resume_opts;
   logic [31:0] entry [2][4];
   logic [127:0] rx_dst;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic aw_held;
   logic w_held;
   logic do_write;
   logic ctrl_write;
   logic [31:0] rd_value;
   logic rd_hit;
   logic wr_hit;
   logic [3:0] wr_dec;
   logic csum_ok;
   logic arp_valid;
   logic ns_valid;
   logic v6_valid;
   logic v4_valid;
   logic [1:0] next_hit;
   logic arp_handled;
   logic ns_handled;
   logic [3:0] set_flags;
   logic [3:0] w1c_flags;
   logic [3:0] resume_clr;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return res;
   endfunction : merge_bytes

   // Returns {hit, entry index, word index} for an address in either match range.
   function automatic logic [3:0] entry_decode(input logic [11:0] addr);
      logic [3:0] res;
      res = 4'h0;
      if (addr[11:4] == OFF_MATCH0_BASE[11:4] && addr[1:0] == 2'h0) begin
         res = {1'b1, 1'b0, addr[3:2]};
      end else if (addr[11:4] == OFF_MATCH1_BASE[11:4] && addr[1:0] == 2'h0) begin
         res = {1'b1, 1'b1, addr[3:2]};
      end
      return res;
   endfunction : entry_decode

   function automatic logic is_mapped(input logic [11:0] addr);
      logic [3:0] dec;
      dec = entry_decode(addr);
      return addr == OFF_CTRL_STATUS || addr == OFF_RESUME_OPTS || dec[3];
   endfunction : is_mapped

   // A solicited-node destination only carries the top 24 bits of the address it stands for.
   function automatic logic dst_match(input logic [127:0] dst, input logic [127:0] ent);
      if (dst[127:24] == SOLICIT_PREFIX) begin
         return ent[127:104] == dst[23:0];
      end
      return ent == dst;
   endfunction : dst_match

   // Bus write side: address and data are taken in either order, answered once both are held.
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_hit = is_mapped(wr_addr);
   assign wr_dec = entry_decode(wr_addr);
   assign ctrl_write = do_write && wr_addr == OFF_CTRL_STATUS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         wr_addr <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         wr_addr <= s_axi_awaddr;
      end else if (do_write) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         wr_data <= 32'h0000_0000;
         wr_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         wr_data <= s_axi_wdata;
         wr_strb <= s_axi_wstrb;
      end else if (do_write) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Control bits, with resume able to drop the SYN wake enables.
   assign resume_clr = {2'b00, {2{resume_done && resume_opts[BIT_RES_CLR_FLAGS]}}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RESET;
      end else begin
         if (ctrl_write) begin
            ctrl <= merge_bytes(ctrl, wr_data, wr_strb) & CTRL_RW_MASK;
         end
         if (resume_done && resume_opts[BIT_RES_CLR_ENABLES]) begin
            ctrl[BIT_V6_WAKE] <= 1'b0;
            ctrl[BIT_V4_WAKE] <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resume_opts <= 2'b00;
      end else if (do_write && wr_addr == OFF_RESUME_OPTS && wr_strb[0]) begin
         resume_opts <= wr_data[1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int e = 0; e < 2; e++) begin
            for (int w = 0; w < 4; w++) begin
               entry[e][w] <= ENTRY_RESET;
            end
         end
      end else if (do_write && wr_dec[3]) begin
         entry[wr_dec[2]][wr_dec[1:0]] <= merge_bytes(entry[wr_dec[2]][wr_dec[1:0]], wr_data, wr_strb);
      end
   end

   // Flags: order is {NS, ARP, IPv6 SYN, IPv4 SYN}; a set in the clearing cycle wins.
   assign w1c_flags = (ctrl_write && wr_strb[0]) ? wr_data[BIT_NS_FLAG:BIT_V4_RCD] : 4'h0;
   assign set_flags = {ns_valid, arp_valid, v6_valid, v4_valid};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags <= 4'h0;
      end else begin
         flags <= (flags & ~w1c_flags & ~resume_clr) | set_flags;
      end
   end

   // Bus read side.
   always_comb begin
      logic [3:0] dec;
      dec = entry_decode(s_axi_araddr);
      rd_value = 32'h0000_0000;
      rd_hit = 1'b1;
      if (s_axi_araddr == OFF_CTRL_STATUS) begin
         rd_value = ctrl;
         rd_value[BIT_NS_FLAG:BIT_V4_RCD] = flags;
      end else if (s_axi_araddr == OFF_RESUME_OPTS) begin
         rd_value = {30'h0, resume_opts};
      end else if (dec[3]) begin
         rd_value = entry[dec[2]][dec[1:0]];
      end else begin
         rd_hit = 1'b0;
      end
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_value;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // The destination arrives byte-serially, so the first byte ends up at the top.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_dst <= 128'h0;
      end else if (rx_dst_byte_valid) begin
         rx_dst <= {rx_dst[119:0], rx_dst_byte};
      end
   end

   // Frame qualification at the frame summary.
   assign csum_ok = rx_fcs_ok && (ctrl[BIT_CSUM_OFF] || (rx_ip_csum_ok && rx_l4_csum_ok));
   assign arp_valid = rx_frame_end && rx_is_arp && csum_ok;
   assign ns_valid = rx_frame_end && rx_is_ns && csum_ok;
   assign v6_valid = rx_frame_end && rx_is_v6_syn && csum_ok;
   assign v4_valid = rx_frame_end && rx_is_v4_syn && csum_ok;

   always_comb begin
      next_hit = 2'b00;
      if (rx_is_ipv6 && ctrl[BIT_NS_ON] && rx_eth_dst_ok) begin
         for (int e = 0; e < 2; e++) begin
            next_hit[e] = dst_match(rx_dst, {entry[e][3], entry[e][2], entry[e][1], entry[e][0]});
         end
      end
   end

   assign arp_handled = arp_valid && ctrl[BIT_ARP_ON] && rx_targets_me && rx_eth_dst_ok;
   assign ns_handled = ns_valid && ctrl[BIT_NS_ON] && rx_targets_me && (next_hit != 2'b00);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         verdict_valid <= 1'b0;
         frame_pass <= 1'b0;
         arp_respond <= 1'b0;
         ns_respond <= 1'b0;
         ns_dst_hit <= 2'b00;
         wake_req <= 1'b0;
      end else begin
         verdict_valid <= rx_frame_end;
         frame_pass <= arp_handled ? ctrl[BIT_FWD_ARP] : (ns_handled ? ctrl[BIT_FWD_NS] : 1'b1);
         arp_respond <= arp_handled;
         ns_respond <= ns_handled;
         ns_dst_hit <= rx_frame_end ? next_hit : 2'b00;
         wake_req <= (v6_valid && ctrl[BIT_V6_WAKE]) || (v4_valid && ctrl[BIT_V4_WAKE]);
      end
   end

   // Entry 0 is preferred when both entries hit.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         advert_src_addr <= 128'h0;
      end else if (ns_handled) begin
         if (ctrl[BIT_ADV_SEL]) begin
            advert_src_addr <= next_hit[0] ? {entry[0][3], entry[0][2], entry[0][1], entry[0][0]}
                                          : {entry[1][3], entry[1][2], entry[1][1], entry[1][0]};
         end else begin
            advert_src_addr <= rx_ns_target;
         end
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_good_frame;
      rx_frame_end && rx_fcs_ok;
   endsequence

   sequence s_arp_answered;
      ##1 arp_respond;
   endsequence

   a_csum_gate_on: assert property (arp_respond |->
      $past(rx_fcs_ok && (ctrl[BIT_CSUM_OFF] || (rx_ip_csum_ok && rx_l4_csum_ok))))
      else $error("ARP answered without a good checksum set.");
   a_csum_off_fcs: assert property (s_good_frame ##0 (rx_is_arp && ctrl[BIT_CSUM_OFF] && ctrl[BIT_ARP_ON]
                                    && rx_targets_me && rx_eth_dst_ok) |-> s_arp_answered)
      else $error("ARP with good FCS not answered while checksums are off.");
   a_forward_arp: assert property (arp_respond |-> frame_pass == $past(ctrl[BIT_FWD_ARP]))
      else $error("Handled ARP frame verdict ignores the forward bit.");
   a_forward_ns: assert property (ns_respond && !arp_respond |-> frame_pass == $past(ctrl[BIT_FWD_NS]))
      else $error("Handled NS frame verdict ignores the forward bit.");
   a_advert_target: assert property (ns_respond && !$past(ctrl[BIT_ADV_SEL]) |->
      advert_src_addr == $past(rx_ns_target))
      else $error("Advert source is not the solicitation target.");
   a_ns_flag_set: assert property (ns_valid |=> flags[3])
      else $error("NS received flag not set.");
   a_arp_flag_clear: assert property ($fell(flags[2]) |->
      $past(ctrl_write && wr_strb[0] && wr_data[BIT_ARP_FLAG]))
      else $error("ARP flag dropped without a write of one.");
   a_v6_flag_set: assert property (v6_valid |=> flags[1])
      else $error("IPv6 SYN flag not set.");
   a_v4_flag_set: assert property (v4_valid |=> flags[0])
      else $error("IPv4 SYN flag not set.");
   a_resume_flags: assert property (resume_done && resume_opts[BIT_RES_CLR_FLAGS] && !v6_valid && !v4_valid
                                    |=> flags[1:0] == 2'b00)
      else $error("Resume left SYN flags set.");
   a_ns_enable: assert property (ns_respond |-> $past(ctrl[BIT_NS_ON]) && ns_dst_hit != 2'b00)
      else $error("NS answered while offload is off or without a hit.");
   a_arp_enable: assert property (arp_respond |-> $past(ctrl[BIT_ARP_ON]))
      else $error("ARP answered while offload is off.");
   a_syn_wake: assert property (wake_req |->
      $past((rx_is_v6_syn && ctrl[BIT_V6_WAKE]) || (rx_is_v4_syn && ctrl[BIT_V4_WAKE])))
      else $error("Wake raised without an enabled SYN source.");
   a_resume_enables: assert property (resume_done && resume_opts[BIT_RES_CLR_ENABLES] |=> ctrl[1:0] == 2'b00)
      else $error("Resume left SYN wake enables set.");
   a_match_scope: assert property (ns_dst_hit != 2'b00 |-> $past(rx_eth_dst_ok && ctrl[BIT_NS_ON]))
      else $error("Entry hit reported for an unqualified frame.");
   a_dst_order: assert property (rx_dst_byte_valid |=> rx_dst[7:0] == $past(rx_dst_byte))
      else $error("Destination byte not shifted in at the bottom.");

endmodule : wocns_ctrl
